// [src/fsk_tone_params.svh]
// constants of the tone divider and select block
// Notes on behaviour
// R1 - normal polarity, keying present: mark clock feeds divider, space blocked
// R2 - normal polarity, keying absent: space clock feeds divider, mark blocked
// R3 - reverse polarity: mark routed without keying, space once keying arrives
// R4 - selected clock divided by 8 through three toggle stages, always running
// R5 - divide-by-8 output drives wide tone and clocks the narrow chain
// R6 - narrow chain enabled only in the three narrow modes
// R7 - narrow divide-by-10 is gated divide-by-5 then one toggle stage
// R8 - divide-by-5 advances on falling edge of divide-by-8 output, gate open
// R9 - four counted pulses set gate; fifth clears it and emits one pulse
// R10 - final toggle flips per divide-by-5 pulse, giving the narrow tone
// R11 - mixer reference path selects 23,800 Hz in diversity, else 26,050 Hz
// R12 - mixer reference always presented to the decade counter shaper
// R13 - undivided mixer reference bypass passes only in wide mode
// R14 - mixer decade counter enabled only in diversity, otherwise held off
// R15 - enabled decade counter gives one output per ten input pulses
// R16 - decade output goes to transmit mixer and receive injection output
// R17 - keying source asserts pulse during loop current, none when open
// R18 - synchronous reset clears every divider stage and gating flag
// R19 - operating mode select distinguishes the five operating modes
`ifndef FSK_TONE_PARAMS_SVH
`define FSK_TONE_PARAMS_SVH

`define OFF_CTRL     32'h0000_0000
`define OFF_STATUS   32'h0000_0004
`define CTRL_REV_RST 1'b0
`define MODE_LAST    3'h4
`define DIV8_LAST    3'h7
`define DIV5_GATE_AT 2'h3
`define DECADE_MOD   10
`define SYNC_KEY     0
`define SYNC_MARK    1
`define SYNC_SPACE   2
`define SYNC_MIX     3

`endif

// [src/fsk_tone_pkg.sv]
// types shared by the tone divider and select block
package fsk_tone_pkg;

  typedef enum logic [2:0] {
    MODE_WIDE,
    MODE_NARROW,
    MODE_NARROW_DIV,
    MODE_NARROW_VOICE,
    MODE_VOICE
  } mode_t;

  typedef struct packed {
    logic [27:0] rsvd;
    mode_t       mode;
    logic        rev;
  } ctrl_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [3:0]  dec_cnt;
    logic        dec_out;
    logic [1:0]  cnt5;
    logic        gate;
    logic        narrow_tone;
    logic        wide_tone;
    logic        sel_mark;
    logic        key;
  } status_t;

endpackage : fsk_tone_pkg

// [src/fsk_tone_divider_select.sv]
// tone source select, dividers and mixer reference path with AHB-Lite regs
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "fsk_tone_params.svh"

module fsk_tone_divider_select
  import fsk_tone_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int DECADE_MOD = `DECADE_MOD
) (
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_HSEL,
  input  wire logic [ADDR_W-1:0] I_HADDR,
  input  wire logic [1:0]        I_HTRANS,
  input  wire logic              I_HWRITE,
  input  wire logic [2:0]        I_HSIZE,
  input  wire logic [31:0]       I_HWDATA,
  input  wire logic              I_HREADY,
  output logic      [31:0]       O_HRDATA,
  output logic                   O_HREADYOUT,
  output logic                   O_HRESP,
  input  wire logic              I_KEY_PULSE,
  input  wire logic              I_MARK_REF,
  input  wire logic              I_SPACE_REF,
  input  wire logic              I_MIX_REF,
  output logic                   O_SEL_REF,
  output logic                   O_WIDE_TONE,
  output logic                   O_NARROW_TONE,
  output logic                   O_MIX_PATH_DIV,
  output logic                   O_MIX_SHAPER,
  output logic                   O_MIX_BYPASS,
  output logic                   O_MIX_OUT,
  output logic                   O_RX_INJECT
);

  // decode needs address bit 2; the decade count is a 4-bit register
  if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end
  if (DECADE_MOD < 2 || DECADE_MOD > 16) begin : g_bad_decade
    $error("DECADE_MOD out of range");
  end

  localparam logic [3:0] DEC_LAST = 4'(DECADE_MOD - 1);
  localparam logic [3:0] DEC_HALF = 4'(DECADE_MOD / 2);

  // register file
  logic              rev_r;
  mode_t             mode_r;
  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [31:0]       hrdata_r;

  // synchronisers: s1 is read only by s2
  logic [3:0]        s1_r;
  logic [3:0]        s2_r;
  logic [3:0]        s3_r;

  // dividers
  logic              sel_prev_r;
  logic [2:0]        div8_r;
  logic [1:0]        cnt5_r;
  logic              gate_r;
  logic              tone_r;
  logic [3:0]        dec_cnt_r;
  logic              dec_out_r;
  logic              bypass_r;
  logic              path_div_r;

  wire               bus_go    = I_HSEL && I_HTRANS[1] && I_HREADY;
  wire [ADDR_W-1:0]  rd_addr   = {I_HADDR[ADDR_W-1:2], 2'b00};
  wire               rd_ctrl   = rd_addr == ADDR_W'(`OFF_CTRL);
  wire               rd_stat   = rd_addr == ADDR_W'(`OFF_STATUS);
  wire               wr_ctrl   = wr_pend_r
                                 && wr_addr_r == ADDR_W'(`OFF_CTRL);
  ctrl_t             wr_word;
  ctrl_t             ctrl_word;
  status_t           stat_word;
  wire               mode_ok   = 3'(wr_word.mode) <= `MODE_LAST;
  wire [31:0]        rd_word   = rd_ctrl ? ctrl_word :
                                 rd_stat ? stat_word : 32'h0000_0000;

  // mode decode
  wire               wide      = mode_r == MODE_WIDE;
  wire               diversity = mode_r == MODE_NARROW_DIV;
  wire               narrow_en = mode_r == MODE_NARROW      // R6
                                 || mode_r == MODE_NARROW_DIV
                                 || mode_r == MODE_NARROW_VOICE;

  // source select
  wire               key_s     = s2_r[`SYNC_KEY];
  wire               sel_mark  = rev_r ? !key_s : key_s;    // R1 R2 R3
  wire               sel_lvl   = sel_mark ? s2_r[`SYNC_MARK]
                                          : s2_r[`SYNC_SPACE];
  wire               sel_rise  = sel_lvl && !sel_prev_r;
  wire               d8_fall   = sel_rise && div8_r == `DIV8_LAST; // R5 R8
  wire               d5_pulse  = narrow_en && d8_fall && gate_r;   // R9
  wire               mix_rise  = s2_r[`SYNC_MIX] && !s3_r[`SYNC_MIX];
  wire               dec_hi    = dec_cnt_r >= DEC_HALF;

  assign wr_word   = ctrl_t'(I_HWDATA);
  assign ctrl_word = ctrl_t'({28'h000_0000, mode_r, rev_r});
  assign stat_word = status_t'({20'h0_0000, dec_cnt_r, dec_out_r,
                                cnt5_r, gate_r, tone_r, div8_r[2],
                                sel_mark, key_s});

  assign O_HRDATA       = hrdata_r;
  assign O_HREADYOUT    = 1'b1;
  assign O_HRESP        = 1'b0;
  assign O_SEL_REF      = sel_prev_r;
  assign O_WIDE_TONE    = div8_r[2];                      // R5
  assign O_NARROW_TONE  = tone_r;
  assign O_MIX_PATH_DIV = path_div_r;
  assign O_MIX_SHAPER   = s3_r[`SYNC_MIX];                // R12
  assign O_MIX_BYPASS   = bypass_r;
  assign O_MIX_OUT      = dec_out_r;                      // R16
  assign O_RX_INJECT    = dec_out_r;                      // R16

  // bus slave, zero wait: read data captured in the address phase
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= bus_go && I_HWRITE;
      wr_addr_r <= rd_addr;
      if (bus_go && !I_HWRITE) begin
        hrdata_r <= rd_word;
      end
    end
  end

  // illegal mode codes are refused so the selector never leaves the set
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rev_r  <= `CTRL_REV_RST;
      mode_r <= MODE_WIDE;
    end else if (wr_ctrl) begin
      rev_r <= wr_word.rev;
      if (mode_ok) begin
        mode_r <= wr_word.mode;                           // R19
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
    end else begin
      s1_r <= {I_MIX_REF, I_SPACE_REF, I_MARK_REF, I_KEY_PULSE};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // three toggle stages rippling equal a binary count
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sel_prev_r <= 1'b0;
      div8_r     <= 3'h0;                                 // R18
    end else begin
      sel_prev_r <= sel_lvl;
      if (sel_rise) begin
        div8_r <= div8_r + 3'h1;                          // R4
      end
    end
  end

  // gated divide-by-5; supply removal clears the stages
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !narrow_en) begin
      cnt5_r <= 2'h0;                                     // R18 R6
      gate_r <= 1'b0;
    end else if (d8_fall) begin                           // R8
      if (gate_r) begin
        gate_r <= 1'b0;                                   // R9
      end else if (cnt5_r == `DIV5_GATE_AT) begin
        cnt5_r <= 2'h0;
        gate_r <= 1'b1;                                   // R9
      end else begin
        cnt5_r <= cnt5_r + 2'h1;                          // R7
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !narrow_en) begin
      tone_r <= 1'b0;
    end else if (d5_pulse) begin
      tone_r <= !tone_r;                                  // R10 R7
    end
  end

  // decade counter: high for the upper half of the count
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !diversity) begin
      dec_cnt_r <= 4'h0;                                  // R14 R18
    end else if (mix_rise) begin
      dec_cnt_r <= (dec_cnt_r == DEC_LAST) ? 4'h0         // R15
                                           : dec_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      dec_out_r  <= 1'b0;
      bypass_r   <= 1'b0;
      path_div_r <= 1'b0;
    end else begin
      dec_out_r  <= diversity && dec_hi;                  // R15
      bypass_r   <= wide && s2_r[`SYNC_MIX];              // R13
      path_div_r <= diversity;                            // R11
    end
  end

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  a_norm_mark_route: assert property (                    // R1
    !rev_r && key_s |-> sel_mark
      ##1 O_SEL_REF == $past(s2_r[`SYNC_MARK]))
    else $error("mark not routed with keying");

  a_norm_space_route: assert property (                   // R2
    !rev_r && !key_s |-> !sel_mark
      ##1 O_SEL_REF == $past(s2_r[`SYNC_SPACE]))
    else $error("space not routed without keying");

  a_rev_swap_route: assert property (                     // R3
    rev_r |-> sel_mark == !key_s
      ##1 O_SEL_REF == $past(key_s ? s2_r[`SYNC_SPACE]
                                   : s2_r[`SYNC_MARK]))
    else $error("reverse polarity routing wrong");

  a_div8_advance: assert property (                       // R4
    sel_rise |=> div8_r == 3'($past(div8_r) + 3'h1))
    else $error("divide-by-8 did not advance");

  a_wide_falls: assert property (                         // R5
    d8_fall |=> !O_WIDE_TONE)
    else $error("wide tone did not fall on wrap");

  a_shaper_feed: assert property (                        // R12
    ##1 O_MIX_SHAPER == $past(s2_r[`SYNC_MIX]))
    else $error("mixer shaper not fed");

  a_narrow_held: assert property (                        // R6
    !narrow_en |=> cnt5_r == 2'h0 && !gate_r && !tone_r)
    else $error("narrow chain not held off");

  a_gate_sets: assert property (                          // R9
    narrow_en && d8_fall && !gate_r && cnt5_r == `DIV5_GATE_AT
      ##1 narrow_en |-> gate_r && cnt5_r == 2'h0)
    else $error("gate not set after four pulses");

  a_gate_blocks: assert property (                        // R9
    narrow_en && d8_fall && gate_r ##1 narrow_en
      |-> !gate_r && $stable(cnt5_r))
    else $error("fifth pulse not gated");

  a_tone_toggles: assert property (                       // R10
    d5_pulse ##1 narrow_en |-> tone_r != $past(tone_r))
    else $error("narrow tone did not toggle");

  a_bypass_blocked: assert property (                     // R13
    !wide ##1 !wide |-> !bypass_r)
    else $error("bypass open outside wide mode");

  a_decade_off: assert property (                         // R14
    !diversity |=> dec_cnt_r == 4'h0 && !dec_out_r)
    else $error("decade counter not held off");

  a_decade_wrap: assert property (                        // R15
    diversity && mix_rise && dec_cnt_r == DEC_LAST ##1 diversity
      |-> dec_cnt_r == 4'h0)
    else $error("decade counter did not wrap");

  a_inject_pair: assert property (                        // R16
    O_MIX_OUT == O_RX_INJECT)
    else $error("injection output differs from mixer output");

  a_path_select: assert property (                        // R11
    ##1 O_MIX_PATH_DIV == $past(diversity))
    else $error("mixer path select wrong");

  a_reset_clears: assert property (                       // R18
    @(posedge I_CORE_CLK) disable iff (1'b0)
    I_RST |=> div8_r == 3'h0 && cnt5_r == 2'h0 && !gate_r
      && dec_cnt_r == 4'h0)
    else $error("reset left divider state");

  c_narrow_pulse: cover property (d5_pulse);
  c_decade_wrap: cover property (
    diversity && mix_rise && dec_cnt_r == DEC_LAST);
  c_rev_mark: cover property (rev_r && !key_s && sel_rise);
  c_wide_bypass: cover property (wide && bypass_r);
  c_narrow_div: cover property (diversity && narrow_en && d5_pulse);

endmodule : fsk_tone_divider_select

// [bench/fsk_loop_partner.sv]
// far-side model: loop keying source and reference oscillators
`timescale 1ns/1ps

module fsk_loop_partner #(
  parameter int MARK_HALF  = 55,
  parameter int SPACE_HALF = 80,
  parameter int MIX_HALF   = 65
) (
  input  wire logic i_key,
  input  wire logic i_run,
  output logic      o_key_pulse,
  output logic      o_mark_ref,
  output logic      o_space_ref,
  output logic      o_mix_ref
);
  // pulse high while loop current flows
  assign o_key_pulse = i_key;
  // stopped oscillators rest low so no stray edge reaches the dividers
  initial begin
    o_mark_ref  = 1'b0;
    o_space_ref = 1'b0;
    o_mix_ref   = 1'b0;
  end
  always #(MARK_HALF) o_mark_ref = i_run & ~o_mark_ref;
  always #(SPACE_HALF) o_space_ref = i_run & ~o_space_ref;
  always #(MIX_HALF) o_mix_ref = i_run & ~o_mix_ref;
endmodule : fsk_loop_partner

// [bench/tb.sv]
// self-checking bench for the tone divider and select block
`timescale 1ns/1ps
`include "fsk_tone_params.svh"

module tb;
  logic        clk = 1'b0;
  logic        rst, hsel, hwrite, key, run;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        hrdy, hresp, key_p, mark, space, mix;
  logic        sel, wide, narrow, pdiv, shaper, byp, mout, inj;
  logic [7:0]  cur, prv;
  int          cnt [8];
  int          inj_bad, n_fail, compares;

  always #2.5 clk = ~clk;

  fsk_loop_partner u_fsk_loop_partner (
    .i_key(key), .i_run(run), .o_key_pulse(key_p),
    .o_mark_ref(mark), .o_space_ref(space), .o_mix_ref(mix));

  fsk_tone_divider_select u_fsk_tone_divider_select (
    .I_CORE_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HRDATA(hrdata),
    .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_KEY_PULSE(key_p),
    .I_MARK_REF(mark), .I_SPACE_REF(space), .I_MIX_REF(mix),
    .O_SEL_REF(sel), .O_WIDE_TONE(wide), .O_NARROW_TONE(narrow),
    .O_MIX_PATH_DIV(pdiv), .O_MIX_SHAPER(shaper), .O_MIX_BYPASS(byp),
    .O_MIX_OUT(mout), .O_RX_INJECT(inj));

  // rising-edge counters; windows compare deltas at a fixed phase
  assign cur = {mark, mix, byp, mout, shaper, narrow, wide, sel};
  always @(posedge clk) begin
    prv <= cur;
    if (inj !== mout) inj_bad <= inj_bad + 1;
    for (int i = 0; i < 8; i++)
      if (cur[i] === 1'b1 && prv[i] === 1'b0) cnt[i] <= cnt[i] + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a[11:0];
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    chk("resp", 32'h0, {31'h0, hresp});
    chk("ready", 32'h1, {31'h0, hrdy});
  endtask : bus

  // window of n rises of counter k, started 8 cycles after one rise
  task automatic win(input int k, input int n, output int d [8]);
    int s [8];
    int e;
    e = cnt[k];
    wait (cnt[k] != e);
    repeat (8) @(posedge clk);
    s = cnt;
    wait (cnt[k] == s[k] + n);
    repeat (8) @(posedge clk);
    foreach (d[i]) d[i] = cnt[i] - s[i];
  endtask : win

  task automatic close_out();
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin : watchdog
    repeat (60000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial begin : main
    logic [31:0] rd;
    int          d [8];
    rst    <= 1'b1;
    hsel   <= 1'b0;
    haddr  <= 12'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize  <= 3'h2;
    hwdata <= 32'h0;
    key    <= 1'b0;
    run    <= 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(0, `OFF_CTRL, 0, rd);
    chk("ctrl_rst", 32'h0, rd);
    bus(0, `OFF_STATUS, 0, rd);
    chk("stat_rst", 32'h0, rd);
    run <= 1'b1;
    for (int m = 0; m < 5; m++) begin
      bus(1, `OFF_CTRL, m << 1, rd);
      bus(0, `OFF_CTRL, 0, rd);
      chk("ctrl", m << 1, rd);
      win(0, 80, d);
      chk("wide", 10, d[1]);
      chk("narrow", (m >= 1 && m <= 3) ? 1 : 0, d[2]);
      win(6, 20, d);
      chk("shaper", 20, d[3]);
      chk("mixout", (m == 2) ? 2 : 0, d[4]);
      chk("bypass", (m == 0) ? 20 : 0, d[5]);
      chk("path", m == 2, pdiv);
    end
    // mode codes past the last are refused, rev still lands
    bus(1, `OFF_CTRL, 32'h0000_000B, rd);
    bus(0, `OFF_CTRL, 0, rd);
    chk("ctrl_bad", 32'h0000_0009, rd);
    bus(1, 32'h0000_0008, 32'h0000_000F, rd);
    bus(0, 32'h0000_0008, 0, rd);
    chk("unmapped", 32'h0, rd);
    for (int p = 0; p < 4; p++) begin
      key <= p[0];
      bus(1, `OFF_CTRL, p >> 1, rd);
      repeat (20) @(posedge clk);
      bus(0, `OFF_STATUS, 0, rd);
      chk("selmark", p[0] ^ p[1], rd[1]);
      win(7, 16, d);
      chk("route", p[0] ^ p[1], d[0] == 16);
    end
    // second reset with dividers mid-count
    run <= 1'b0;
    key <= 1'b0;
    repeat (40) @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(0, `OFF_STATUS, 0, rd);
    chk("stat_rst2", 32'h0, rd);
    bus(0, `OFF_CTRL, 0, rd);
    chk("ctrl_rst2", 32'h0, rd);
    chk("inject", 0, inj_bad);
    close_out();
  end
endmodule : tb
